//--- common/pswfr_params.svh
// Timing and encoding constants for the power switch fault reporter
`ifndef PSWFR_PARAMS_SVH
`define PSWFR_PARAMS_SVH
`define PSWFR_CLK_HZ 25000000
`define PSWFR_TEMP_PWM_HZ 9000
`define PSWFR_TEMP_PERIOD_CYC (`PSWFR_CLK_HZ / `PSWFR_TEMP_PWM_HZ)
`define PSWFR_MIN_PULSE_NS 30
`define PSWFR_CLK_NS 40
`define PSWFR_MIN_PULSE_CYC \
    ((`PSWFR_MIN_PULSE_NS + `PSWFR_CLK_NS - 1) / `PSWFR_CLK_NS)
`define PSWFR_DUTY_LO_PCT 3
`define PSWFR_DUTY_HI_PCT 82
`define PSWFR_BLANK_CYC 8'h05
`define PSWFR_SC_CLEAR_CYC 16'h0100
`define PSWFR_PIN_FILT_CYC 8'hFF
`define PSWFR_SLEW_GND 2'h0
`define PSWFR_SLEW_AUX 2'h1
`define PSWFR_SLEW_RES 2'h2
`define PSWFR_SLEW_OPEN 2'h3
`endif

//--- common/pswfr_pkg.sv
// Types shared by the power switch fault reporter
package pswfr_pkg;
    typedef enum logic [1:0] {
        PSWFR_IDM_BLANK = 2'h1,
        PSWFR_IDM_WATCH = 2'h0,
        PSWFR_IDM_ON = 2'h2
    } pswfr_idm_t;

    typedef struct packed {
        logic gan_hot;
        logic drv_hot;
        logic uv_low;
        logic oc_det;
        logic sc_det;
    } pswfr_sense_t;

    typedef struct packed {
        logic aux_regulator_en;
        logic bias_converter_en;
        logic switch_gate;
    } pswfr_power_t;
endpackage

//--- hw/pswfr_temp_pwm.sv
// Duty-coded die temperature output
`timescale 1ns/1ns
`include "pswfr_params.svh"
module pswfr_temp_pwm #(
    parameter int PERIOD = `PSWFR_TEMP_PERIOD_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] temp_code_in,
    input wire logic over_temp_in,
    output logic temp_pwm_out
);
    typedef struct packed {
        logic [11:0] cnt;
        logic [11:0] width;
        logic pwm;
    } pswfr_pwm_st_t;
    pswfr_pwm_st_t st;
    pswfr_pwm_st_t next_st;
    localparam logic [11:0] LAST = 12'(PERIOD - 1);
    localparam int LO = PERIOD * `PSWFR_DUTY_LO_PCT / 100;
    localparam int SPAN =
        PERIOD * (`PSWFR_DUTY_HI_PCT - `PSWFR_DUTY_LO_PCT) / 100;

    // Width grows linearly with code; codes past 150C keep rising up to a cap of PERIOD-1 cycles
    function automatic logic [11:0] width_of(input logic [7:0] c);
        int w;
        w = LO + (SPAN * int'(c)) / 200;
        if (w < `PSWFR_MIN_PULSE_CYC) begin
            w = `PSWFR_MIN_PULSE_CYC;
        end
        if (w > PERIOD - 1) begin
            w = PERIOD - 1;
        end
        return 12'(w);
    endfunction

    // Value sampled once per period so a pulse is never cut short
    always_comb begin
        next_st = st;
        next_st.cnt = (st.cnt == LAST) ? 12'h000 : st.cnt + 12'h001;
        if (st.cnt == LAST) begin
            next_st.width = width_of(temp_code_in);
        end
        next_st.pwm = over_temp_in | (next_st.cnt < next_st.width);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign temp_pwm_out = st.pwm;
endmodule

//--- hw/pswfr_ideal_diode.sv
// Ideal-diode gate control used during switch-die overtemperature
`timescale 1ns/1ns
`include "pswfr_params.svh"
module pswfr_ideal_diode (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic active_in,
    input wire logic cmd_fall_in,
    input wire logic reverse_in,
    input wire logic forward_in,
    output logic gate_out
);
    typedef struct packed {
        pswfr_pkg::pswfr_idm_t state;
        logic [7:0] blank;
    } pswfr_idm_st_t;
    pswfr_idm_st_t st;
    pswfr_idm_st_t next_st;

    // Entry is always the watch state; a command fall forces blanking
    always_comb begin
        next_st = st;
        if (!active_in) begin
            next_st.state = pswfr_pkg::PSWFR_IDM_WATCH;
            next_st.blank = 8'h00;
        end else if (cmd_fall_in) begin
            next_st.state = pswfr_pkg::PSWFR_IDM_BLANK;
            next_st.blank = `PSWFR_BLANK_CYC;
        end else begin
            case (st.state)
                pswfr_pkg::PSWFR_IDM_BLANK: begin
                    // Fixed wait avoids sticking if no drain rise appears
                    next_st.blank = st.blank - 8'h01;
                    if (st.blank == 8'h01) begin
                        next_st.state = pswfr_pkg::PSWFR_IDM_WATCH;
                    end
                end
                pswfr_pkg::PSWFR_IDM_WATCH: begin
                    if (reverse_in) begin
                        next_st.state = pswfr_pkg::PSWFR_IDM_ON;
                    end
                end
                pswfr_pkg::PSWFR_IDM_ON: begin
                    if (forward_in) begin
                        next_st.state = pswfr_pkg::PSWFR_IDM_WATCH;
                    end
                end
                default: begin
                    next_st.state = pswfr_pkg::PSWFR_IDM_WATCH;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign gate_out = (st.state == pswfr_pkg::PSWFR_IDM_ON);
endmodule

//--- hw/pswfr_top.sv
// Fault protection and reporting logic for a driven power switch
// What this block does
// - Switch-die overtemperature hands the switch to ideal-diode control.
// - Ideal-diode control: off for forward current, on for reverse current.
// - Driver overtemperature disables aux regulator, bias converter, switch.
// - No ideal-diode control during driver overtemperature; switch off.
// - Fault output asserts for either or both overtemperature states.
// - Fault clears and switching resumes only when both conditions clear.
// - Driver overtemperature clearing with switch-die hot resumes ideal-diode.
// - Supply lockout stops switching, holds switch off, drives fault low.
// - Aux regulator and bias converter enable on lockout release edge.
// - Monitored slew pin open holds switch off and asserts fault.
// - Variant without overcurrent output reports all faults on fault output.
// - Two-output codes: none 1/1, others 0/1, overcurrent 1/0, short 0/0.
// - Slew pin grounded selects 150V/ns, aux rail 100V/ns, resistor between.
// - Aux-tied slew pin detected once at power-up then no longer monitored.
// - Temperature output is PWM near 9kHz, refreshed once per period.
// - Duty spans about 3% to 82% over target range; least pulse 30ns.
// - Above 150C duty keeps rising linearly up to one cycle short of the period, then holds.
// - Overtemperature fault holds temperature output high until it clears.
// - Overcurrent indication clears when command goes low; next cycle normal.
// - Short-circuit latches switch off until command held low long enough.
`timescale 1ns/1ns
`include "pswfr_params.svh"
module pswfr_top #(
    parameter bit HAS_OC_PIN = 1'b1,
    parameter int SC_CLEAR_CYC = `PSWFR_SC_CLEAR_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SWITCH_CMD_IN,
    input wire logic GAN_HOT_IN,
    input wire logic DRV_HOT_IN,
    input wire logic SUPPLY_LOW_LOCKOUT_IN,
    input wire logic OC_DETECT_IN,
    input wire logic SC_DETECT_IN,
    input wire logic REVERSE_CURRENT_IN,
    input wire logic FORWARD_CURRENT_IN,
    input wire logic [1:0] SLEW_SELECT_PIN_IN,
    input wire logic [7:0] TEMP_CODE_IN,
    input wire logic OVERCURRENT_FLAG_N_IN,
    output logic SWITCH_GATE_OUT,
    output logic SLOW_TURNOFF_OUT,
    output logic AUX_REGULATOR_EN_OUT,
    output logic BIAS_CONVERTER_EN_OUT,
    output logic [1:0] SLEW_SETTING_OUT,
    output logic FAULT_N_OUT,
    output logic OVERCURRENT_FLAG_N_OUT,
    output logic OVERCURRENT_FLAG_N_OE_OUT,
    output logic TEMP_PWM_OUT
);
    typedef struct packed {
        logic strap_done;
        logic fault_only;
        logic slew_locked;
        logic [1:0] slew;
        logic [1:0] slew_cand;
        logic [7:0] slew_filt;
        logic uv_prev;
        logic rails_on;
        logic cmd_prev;
        logic oc_latched;
        logic sc_latched;
        logic [15:0] low_cnt;
        logic gate;
        logic fault_n;
        logic oc_n;
    } pswfr_top_st_t;

    pswfr_top_st_t st;
    pswfr_top_st_t next_st;
    pswfr_pkg::pswfr_sense_t sense;
    logic idm_gate;
    logic cmd_fall;
    logic pin_open;
    logic hold_off;
    logic any_fault_level;

    assign sense = '{gan_hot: GAN_HOT_IN, drv_hot: DRV_HOT_IN,
                     uv_low: SUPPLY_LOW_LOCKOUT_IN, oc_det: OC_DETECT_IN,
                     sc_det: SC_DETECT_IN};
    assign cmd_fall = st.cmd_prev & ~SWITCH_CMD_IN;

    // Open slew pin only matters while the pin is still monitored
    assign pin_open = !st.slew_locked &&
        (st.slew == `PSWFR_SLEW_OPEN);
    assign hold_off = sense.uv_low | sense.drv_hot | pin_open
        | st.sc_latched;
    // Level faults that always pull the fault output low
    assign any_fault_level = sense.uv_low | sense.gan_hot | sense.drv_hot
        | pin_open;

    pswfr_ideal_diode u_idm (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .active_in(sense.gan_hot & ~sense.drv_hot),
        .cmd_fall_in(cmd_fall),
        .reverse_in(REVERSE_CURRENT_IN),
        .forward_in(FORWARD_CURRENT_IN),
        .gate_out(idm_gate)
    );

    pswfr_temp_pwm u_pwm (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .temp_code_in(TEMP_CODE_IN),
        .over_temp_in(sense.gan_hot | sense.drv_hot),
        .temp_pwm_out(TEMP_PWM_OUT)
    );

    // Next-state logic for straps, slew pin, current faults and outputs
    always_comb begin
        next_st = st;
        next_st.cmd_prev = SWITCH_CMD_IN;
        next_st.uv_prev = sense.uv_low;

        // Strap and aux-tie test happen once, on the first clock after reset
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.fault_only = HAS_OC_PIN ? ~OVERCURRENT_FLAG_N_IN
                : 1'b1;
            next_st.slew = SLEW_SELECT_PIN_IN;
            next_st.slew_cand = SLEW_SELECT_PIN_IN;
            next_st.slew_locked =
                (SLEW_SELECT_PIN_IN == `PSWFR_SLEW_AUX);
        end else if (!st.slew_locked) begin
            // Heavy filter: a new reading must hold for a long run
            if (SLEW_SELECT_PIN_IN != st.slew_cand) begin
                next_st.slew_cand = SLEW_SELECT_PIN_IN;
                next_st.slew_filt = 8'h00;
            end else if (st.slew_filt == `PSWFR_PIN_FILT_CYC) begin
                next_st.slew = st.slew_cand;
            end else begin
                next_st.slew_filt = st.slew_filt + 8'h01;
            end
        end

        // Rails come up on lockout release, drop on lockout or driver heat
        if (sense.uv_low | sense.drv_hot) begin
            next_st.rails_on = 1'b0;
        end else if (st.uv_prev & ~sense.uv_low) begin
            next_st.rails_on = 1'b1;
        end else if (!st.rails_on && !st.uv_prev && st.strap_done) begin
            // Driver heat cleared without a lockout edge: restart rails
            next_st.rails_on = 1'b1;
        end

        // Overcurrent is cycle by cycle; command low clears it even while detect is high
        if (sense.oc_det && SWITCH_CMD_IN) begin
            next_st.oc_latched = 1'b1;
        end else if (!SWITCH_CMD_IN) begin
            next_st.oc_latched = 1'b0;
        end

        // Short circuit latches until command low long enough
        if (sense.sc_det) begin
            next_st.sc_latched = 1'b1;
            next_st.low_cnt = 16'h0000;
        end else if (SWITCH_CMD_IN) begin
            next_st.low_cnt = 16'h0000;
        end else if (st.sc_latched) begin
            if (st.low_cnt >= 16'(SC_CLEAR_CYC - 1)) begin
                next_st.sc_latched = 1'b0;
                next_st.low_cnt = 16'h0000;
            end else begin
                next_st.low_cnt = st.low_cnt + 16'h0001;
            end
        end

        // Gate: forced off, ideal-diode, or following the command
        if (hold_off) begin
            next_st.gate = 1'b0;
        end else if (sense.gan_hot) begin
            next_st.gate = idm_gate;
        end else begin
            next_st.gate = SWITCH_CMD_IN & ~next_st.oc_latched
                & ~sense.oc_det;
        end

        // Reporting codes per mode
        if (st.fault_only) begin
            next_st.fault_n = ~(any_fault_level | next_st.oc_latched
                | next_st.sc_latched);
            next_st.oc_n = 1'b1;
        end else begin
            next_st.fault_n = ~(any_fault_level
                | next_st.sc_latched);
            next_st.oc_n = ~(next_st.oc_latched
                | next_st.sc_latched);
        end
    end

    // State register; fault output low until straps are read
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign SWITCH_GATE_OUT = st.gate;
    assign SLOW_TURNOFF_OUT = st.sc_latched;
    assign AUX_REGULATOR_EN_OUT = st.rails_on;
    assign BIAS_CONVERTER_EN_OUT = st.rails_on;
    // Slew code: ground 150V/ns, aux 100V/ns, resistor in between
    assign SLEW_SETTING_OUT = st.slew;
    assign FAULT_N_OUT = st.fault_n;
    assign OVERCURRENT_FLAG_N_OUT = st.oc_n;
    // Pin released during strap sampling so the tie can be read
    assign OVERCURRENT_FLAG_N_OE_OUT = HAS_OC_PIN && st.strap_done
        && !st.fault_only;
endmodule

//--- tb/pswfr_ctrl_model.sv
// System controller model facing the fault reporter
`timescale 1ns/1ns
module pswfr_ctrl_model (
    input wire logic cmd_req_in,
    input wire logic strap_gnd_in,
    input wire logic [1:0] slew_req_in,
    input wire logic oc_n_in,
    input wire logic oc_oe_in,
    output logic switch_cmd_out,
    output logic [1:0] slew_pin_out,
    output logic oc_pin_out
);
    // Command passes straight through; the bench paces it
    assign switch_cmd_out = cmd_req_in;
    // Slew pin only moves when the bench steps it, never noisily
    assign slew_pin_out = slew_req_in;
    // Pin ground strap during power-up, pull-up otherwise
    assign oc_pin_out = oc_oe_in ? oc_n_in : !strap_gnd_in;
endmodule

//--- tb/pswfr_top_sva.sv
// Assertion checker for the power switch fault reporter
`timescale 1ns/1ns
module pswfr_top_sva (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SWITCH_CMD_IN,
    input wire logic GAN_HOT_IN,
    input wire logic DRV_HOT_IN,
    input wire logic SUPPLY_LOW_LOCKOUT_IN,
    input wire logic OC_DETECT_IN,
    input wire logic SC_DETECT_IN,
    input wire logic REVERSE_CURRENT_IN,
    input wire logic FORWARD_CURRENT_IN,
    input wire logic [1:0] SLEW_SELECT_PIN_IN,
    input wire logic SWITCH_GATE_OUT,
    input wire logic SLOW_TURNOFF_OUT,
    input wire logic AUX_REGULATOR_EN_OUT,
    input wire logic BIAS_CONVERTER_EN_OUT,
    input wire logic FAULT_N_OUT,
    input wire logic OVERCURRENT_FLAG_N_OUT,
    input wire logic OVERCURRENT_FLAG_N_OE_OUT,
    input wire logic TEMP_PWM_OUT
);
    logic [1:0] up;
    logic idm_ok;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // Strap edge comes first, so outputs are trusted from the third edge
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    // Only switch-die heat with nothing else holding the switch off
    assign idm_ok = up == 2'h3 && GAN_HOT_IN && !DRV_HOT_IN &&
        !SUPPLY_LOW_LOCKOUT_IN && !SWITCH_CMD_IN &&
        SLEW_SELECT_PIN_IN != 2'h3 && !SLOW_TURNOFF_OUT;
    sequence cool_wait;
        idm_ok [*8];
    endsequence
    sequence rev_flow;
        (idm_ok && REVERSE_CURRENT_IN && !FORWARD_CURRENT_IN) [*2];
    endsequence
    sequence fwd_flow;
        (idm_ok && FORWARD_CURRENT_IN && !REVERSE_CURRENT_IN) [*2];
    endsequence
    idm_on_a: assert property (cool_wait ##1 rev_flow |=>
        SWITCH_GATE_OUT) else $error("gate not on for reverse flow");
    idm_off_a: assert property (cool_wait ##1 fwd_flow |=>
        !SWITCH_GATE_OUT) else $error("gate not off for forward flow");
    drv_off_a: assert property (DRV_HOT_IN |=>
        !SWITCH_GATE_OUT && !AUX_REGULATOR_EN_OUT)
        else $error("driver heat left switch or rail on");
    lockout_off_a: assert property (SUPPLY_LOW_LOCKOUT_IN |=>
        !SWITCH_GATE_OUT && !FAULT_N_OUT) else $error("lockout ignored");
    hot_fault_a: assert property (up == 2'h3 &&
        (GAN_HOT_IN || DRV_HOT_IN) |=> !FAULT_N_OUT)
        else $error("heat without fault");
    temp_high_a: assert property (up == 2'h3 &&
        (GAN_HOT_IN || DRV_HOT_IN) |=> TEMP_PWM_OUT)
        else $error("temperature output not held high");
    rails_pair_a: assert property (
        AUX_REGULATOR_EN_OUT == BIAS_CONVERTER_EN_OUT)
        else $error("rail enables differ");
    rail_rise_a: assert property ($rose(AUX_REGULATOR_EN_OUT) |->
        !$past(SUPPLY_LOW_LOCKOUT_IN) && !$past(DRV_HOT_IN))
        else $error("rails rose during lockout or heat");
    oc_clear_a: assert property (up == 2'h3 && !SWITCH_CMD_IN &&
        !OC_DETECT_IN && !SC_DETECT_IN && !SLOW_TURNOFF_OUT |=>
        OVERCURRENT_FLAG_N_OUT || !OVERCURRENT_FLAG_N_OE_OUT)
        else $error("overcurrent flag kept after command low");
endmodule
bind pswfr_top pswfr_top_sva pswfr_top_sva_i (.CLK_IN(CLK_IN),
    .RESETN_IN(RESETN_IN), .SWITCH_CMD_IN(SWITCH_CMD_IN),
    .GAN_HOT_IN(GAN_HOT_IN), .DRV_HOT_IN(DRV_HOT_IN),
    .SUPPLY_LOW_LOCKOUT_IN(SUPPLY_LOW_LOCKOUT_IN),
    .OC_DETECT_IN(OC_DETECT_IN), .SC_DETECT_IN(SC_DETECT_IN),
    .REVERSE_CURRENT_IN(REVERSE_CURRENT_IN),
    .FORWARD_CURRENT_IN(FORWARD_CURRENT_IN),
    .SLEW_SELECT_PIN_IN(SLEW_SELECT_PIN_IN),
    .SWITCH_GATE_OUT(SWITCH_GATE_OUT), .SLOW_TURNOFF_OUT(SLOW_TURNOFF_OUT),
    .AUX_REGULATOR_EN_OUT(AUX_REGULATOR_EN_OUT),
    .BIAS_CONVERTER_EN_OUT(BIAS_CONVERTER_EN_OUT),
    .FAULT_N_OUT(FAULT_N_OUT),
    .OVERCURRENT_FLAG_N_OUT(OVERCURRENT_FLAG_N_OUT),
    .OVERCURRENT_FLAG_N_OE_OUT(OVERCURRENT_FLAG_N_OE_OUT),
    .TEMP_PWM_OUT(TEMP_PWM_OUT));

//--- tb/pswfr_top_tb.sv
// Self-checking bench for the power switch fault reporter
`timescale 1ns/1ns
`include "pswfr_params.svh"
module pswfr_top_tb;
    localparam int PER = `PSWFR_TEMP_PERIOD_CYC;
    localparam int LO = PER * 3 / 100;
    localparam int HI = PER * 82 / 100;
    localparam int TOL = PER / 50;
    logic clk, rstn, cmd_req, strap_gnd, cmd, oc_pin;
    logic gan, drv, uv, ocd, scd, rev, fwd;
    logic [1:0] slew_req, slew_pin, slew_out;
    logic [7:0] tcode;
    logic gate, slow, aux, bias, fault_n, oc_n, oc_oe, tpwm;
    int bad_count, n_checks, cyc, h0, h1, h2;
    // Rows: heat gan/drv, lockout, oc, short, command | gate fault_n oc_n
    logic [8:0] rows [14] = '{9'h00F, 9'h003, 9'h089, 9'h049, 9'h00F,
        9'h101, 9'h181, 9'h02A, 9'h003, 9'h00F, 9'h018, 9'h008, 9'h003,
        9'h00F};
    pswfr_top #(.HAS_OC_PIN(1'b1), .SC_CLEAR_CYC(4)) pswfr_top_i (
        .CLK_IN(clk), .RESETN_IN(rstn), .SWITCH_CMD_IN(cmd),
        .GAN_HOT_IN(gan), .DRV_HOT_IN(drv), .SUPPLY_LOW_LOCKOUT_IN(uv),
        .OC_DETECT_IN(ocd), .SC_DETECT_IN(scd), .REVERSE_CURRENT_IN(rev),
        .FORWARD_CURRENT_IN(fwd), .SLEW_SELECT_PIN_IN(slew_pin),
        .TEMP_CODE_IN(tcode), .OVERCURRENT_FLAG_N_IN(oc_pin),
        .SWITCH_GATE_OUT(gate), .SLOW_TURNOFF_OUT(slow),
        .AUX_REGULATOR_EN_OUT(aux), .BIAS_CONVERTER_EN_OUT(bias),
        .SLEW_SETTING_OUT(slew_out), .FAULT_N_OUT(fault_n),
        .OVERCURRENT_FLAG_N_OUT(oc_n), .OVERCURRENT_FLAG_N_OE_OUT(oc_oe),
        .TEMP_PWM_OUT(tpwm));
    pswfr_ctrl_model pswfr_ctrl_model_i (.cmd_req_in(cmd_req),
        .strap_gnd_in(strap_gnd), .slew_req_in(slew_req), .oc_n_in(oc_n),
        .oc_oe_in(oc_oe), .switch_cmd_out(cmd), .slew_pin_out(slew_pin),
        .oc_pin_out(oc_pin));
    task automatic chk(input string what, input logic [11:0] seen,
        input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Inputs only move at the falling edge, away from sampling
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Settle two periods, then count high cycles over one whole period
    task automatic duty(input logic [7:0] c, output int h);
        tcode = c;
        cycles(2 * PER);
        h = 0;
        repeat (PER) begin
            @(negedge clk);
            h += int'(tpwm);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole run needs about 26000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        rstn = 1'b0;
        cmd_req = 1'b0;
        strap_gnd = 1'b0;
        {gan, drv, uv, ocd, scd, rev, fwd} = 7'h00;
        slew_req = 2'h0;
        tcode = 8'h00;
        cycles(5);
        rstn = 1'b1;
        cycles(4);
        foreach (rows[i]) begin
            {gan, drv, uv, ocd, scd, cmd_req} = rows[i][8:3];
            cycles(8);
            chk("row", {gate, fault_n, oc_n}, rows[i][2:0]);
        end
        chk("rails up", {aux, bias}, 2'h3);
        $display("done: table");
        cmd_req = 1'b0;
        gan = 1'b1;
        cycles(12);
        chk("temp held", tpwm, 1'b1);
        rev = 1'b1;
        cycles(4);
        chk("reverse on", gate, 1'b1);
        {rev, fwd} = 2'h1;
        cycles(4);
        chk("forward off", gate, 1'b0);
        {rev, fwd, drv} = 3'h5;
        cycles(4);
        chk("driver hot", {gate, aux, bias, fault_n}, 4'h0);
        drv = 1'b0;
        cycles(6);
        chk("idm back", {gate, fault_n}, 2'h2);
        {gan, rev} = 2'h0;
        cycles(4);
        chk("cooled", fault_n, 1'b1);
        $display("done: thermal");
        cmd_req = 1'b1;
        slew_req = 2'h3;
        cycles(300);
        chk("open pin", {gate, fault_n, slew_out}, 4'h3);
        slew_req = 2'h2;
        cycles(300);
        chk("pin tracks", {gate, fault_n, slew_out}, 4'hE);
        $display("done: slew");
        duty(8'h00, h0);
        chk("duty low", h0 > LO - TOL && h0 < LO + TOL, 1'b1);
        duty(8'hC8, h1);
        chk("duty top", h1 > HI - TOL && h1 < HI + TOL, 1'b1);
        duty(8'hF0, h2);
        chk("duty above", h2 > h1 && h2 < PER, 1'b1);
        $display("done: duty");
        strap_gnd = 1'b1;
        rstn = 1'b0;
        cycles(5);
        chk("in reset", {gate, fault_n, oc_oe, aux}, 4'h0);
        rstn = 1'b1;
        cycles(3);
        strap_gnd = 1'b0;
        cycles(3);
        ocd = 1'b1;
        cycles(4);
        chk("oc only fault", {gate, fault_n, oc_oe}, 3'h0);
        {ocd, cmd_req} = 2'h0;
        cycles(4);
        chk("oc cleared", fault_n, 1'b1);
        {scd, cmd_req} = 2'h3;
        cycles(4);
        chk("short only fault", {gate, fault_n}, 2'h0);
        chk("slow turnoff", slow, 1'b1);
        $display("done: strap");
        complete_run();
    end
endmodule
